// [rtl/slsu_pkg.sv]
// Package for the sensor scan unit: register offsets, field positions, codes and states.
// Assumes a 32-bit register bus with byte addresses and one aligned word per register.
package slsu_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_CH = 16;
   localparam int NUM_DEC_EV = 3;
   localparam int THR_W = 16;
   localparam int EXT_W = 6;
   localparam int SDLY_W = 8;
   localparam int TOP_W = 8;
   localparam int PRESC_W = 3;
   localparam int RAM_WORDS = 112;
   localparam int BUF_DEPTH = 16;
   localparam int CH_WORDS = 3;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [9:0] OFF_CTRL = 10'h000;
   localparam logic [9:0] OFF_TIMCTRL = 10'h004;
   localparam logic [9:0] OFF_DECCTRL = 10'h00C;
   localparam logic [9:0] OFF_CMD = 10'h014;
   localparam logic [9:0] OFF_CHANNEL_ENABLE_REG = 10'h018;
   localparam logic [9:0] OFF_SCAN_RESULT_VECTOR = 10'h01C;
   localparam logic [9:0] OFF_STATUS = 10'h020;
   localparam logic [9:0] OFF_PTR = 10'h024;
   localparam logic [9:0] OFF_DECODER_STATE_REG = 10'h030;
   localparam logic [9:0] OFF_SENSSTATE = 10'h034;
   localparam logic [9:0] OFF_IDLE_PIN_CONFIG = 10'h038;
   localparam logic [9:0] OFF_PWRDN = 10'h058;
   localparam logic [9:0] OFF_RAM_LO = 10'h200;
   localparam logic [9:0] OFF_RAM_HI = 10'h3BC;

   // ----------------------------------------------------------------
   // Memory word indices and fields
   // ----------------------------------------------------------------
   localparam logic [6:0] RAM_ST = 7'h00;
   localparam logic [6:0] RAM_BUF = 7'h20;
   localparam logic [6:0] RAM_CH = 7'h30;
   localparam int TIM_PRESC_LSB = 8;
   localparam int TIM_TOP_LSB = 12;
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int PWRDN_RAM = 0;
   localparam int CHT_EXT_LSB = 0;
   localparam int CHT_SDLY_LSB = 8;
   localparam int CHI_EXLOW = 0;
   localparam int CHE_THR_LSB = 0;
   localparam int CHE_LESS = 16;
   localparam int CHE_STORE = 17;
   localparam int TC_COMP_LSB = 0;
   localparam int TC_MASK_LSB = 4;
   localparam int TC_NEXT_LSB = 8;
   localparam int TC_ACT_LSB = 12;
   localparam int TC_CHAIN = 14;

   // ----------------------------------------------------------------
   // Codes and states
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_PERIODIC = 2'h0;
   localparam logic [1:0] MODE_ONESHOT = 2'h1;
   localparam logic [1:0] IDLE_DIS = 2'h0;
   localparam logic [1:0] IDLE_HIGH = 2'h1;
   localparam logic [1:0] IDLE_DAC = 2'h3;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_UP = 2'h1;

   typedef enum logic [2:0] {S_IDLE, S_LOAD, S_EXCITE, S_MEASURE, S_EVAL, S_NEXT, S_DECODE} slsu_fsm_type;

endpackage

// [rtl/slsu_link_if.sv]
// Interface joining the scan core to its period generator and pulse counter.
// Assumes all three ends run on the same system clock.
`timescale 1ns/1ps
interface slsu_link_if import slsu_pkg::*; ();
   logic [PRESC_W-1:0] presc;
   logic [TOP_W-1:0] top;
   logic lf_tick;
   logic tick;
   logic clr;
   logic cnt_en;
   logic pulse;
   logic [THR_W-1:0] thr;
   logic less;
   logic [THR_W-1:0] count;
   logic active;
   modport period_end (input presc, input top, input lf_tick, output tick);
   modport count_end (input clr, input cnt_en, input pulse, input thr, input less, output count, output active);
endinterface // slsu_link_if

// [rtl/slsu_period_gen.sv]
// Scan period generator: divides low-frequency ticks by a power-of-two prescale and top+1.
// Assumes lf_tick is a one-cycle pulse synchronous to sys_clk.
`timescale 1ns/1ps
module slsu_period_gen import slsu_pkg::*; (
   input wire logic sys_clk,
   input wire logic resetn,
   slsu_link_if.period_end lk
);
   typedef struct packed {
      logic [6:0] pre;
      logic [TOP_W-1:0] per;
      logic tick;
   } slsu_per_type;

   slsu_per_type s_q, s_d;
   logic [6:0] pre_top;

   assign pre_top = (7'h1 << lk.presc) - 7'h1;
   assign lk.tick = s_q.tick;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (lk.lf_tick) begin
         if (s_q.pre >= pre_top) begin
            s_d.pre = '0;
            if (s_q.per >= lk.top) begin
               s_d.per = '0;
               s_d.tick = 1'b1;
            end else begin
               s_d.per = s_q.per + 1'b1;
            end
         end else begin
            s_d.pre = s_q.pre + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // slsu_period_gen

// [rtl/slsu_pulse_count.sv]
// Comparator pulse counter with threshold evaluation for one channel at a time.
// Assumes comparator pulses arrive as one-cycle strobes synchronous to sys_clk.
`timescale 1ns/1ps
module slsu_pulse_count import slsu_pkg::*; (
   input wire logic sys_clk,
   input wire logic resetn,
   slsu_link_if.count_end lk
);
   typedef struct packed {
      logic [THR_W-1:0] count;
   } slsu_cnt_type;

   slsu_cnt_type s_q, s_d;

   assign lk.count = s_q.count;
   assign lk.active = lk.less ? (s_q.count < lk.thr) : (s_q.count >= lk.thr);

   always_comb begin
      s_d = s_q;
      if (lk.clr) begin
         s_d.count = '0;
      end else if (lk.cnt_en && lk.pulse && (s_q.count != '1)) begin
         s_d.count = s_q.count + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   a_count_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
      lk.clr |=> (lk.count == '0)) else $error("Pulse count not cleared.");
endmodule // slsu_pulse_count

// [rtl/slsu_top.sv]
// Sensor scan unit core: register slave, scan sequencer, decoder, memory and event outputs.
// Assumes Avalon-MM master with byte addresses; lf_tick, aux_tick and comp_pulse are clock-synchronous strobes.
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module slsu_top import slsu_pkg::*; #(
   parameter int NCH = NUM_CH
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic lf_tick,
   input wire logic aux_tick,
   input wire logic comp_pulse,
   output logic [NCH+NUM_DEC_EV-1:0] event_out,
   output logic [NCH-1:0] pin_out,
   output logic [NCH-1:0] pin_oe,
   output logic [NCH-1:0] dac_sel
);
   localparam int CH_W = $clog2(NCH);

   typedef struct packed {
      slsu_fsm_type fsm;
      logic [CH_W-1:0] ch;
      logic [SDLY_W-1:0] tcnt;
      logic ex_low;
      logic [1:0] mode;
      logic [PRESC_W-1:0] presc;
      logic [TOP_W-1:0] top;
      logic cnt_out_en;
      logic [NCH-1:0] channel_enable_reg;
      logic [NCH-1:0] acc;
      logic [NCH-1:0] scan_res;
      logic [3:0] dec_state;
      logic [3:0] dec_eval;
      logic chained;
      logic [3:0] sens_state;
      logic [2*NCH-1:0] idle_conf;
      logic pd;
      logic running;
      logic [3:0] buf_wr;
      logic wait_r;
      logic [31:0] rdata;
      logic [NCH+NUM_DEC_EV-1:0] ev;
      logic [NCH-1:0] pin_out;
      logic [NCH-1:0] pin_oe;
      logic [NCH-1:0] dac_sel;
   } slsu_state_type;

   slsu_state_type s_q, s_d;
   slsu_link_if lk ();

   // ----------------------------------------------------------------
   // Bus decode and memory
   // ----------------------------------------------------------------
   logic req, take, wr, ram_hit, ram_we, st_we, cmd_start;
   logic [6:0] ram_idx, ch_base, st_base;
   logic [31:0] ram [RAM_WORDS];
   logic [31:0] tim_w, int_w, eval_w, ta, tb;

   assign req = avs_read | avs_write;
   assign take = req & ~s_q.wait_r;
   assign wr = avs_write & take;
   assign ram_hit = (avs_address >= OFF_RAM_LO) && (avs_address <= OFF_RAM_HI);
   assign ram_idx = 7'((avs_address - OFF_RAM_LO) >> 2);
   assign ram_we = wr & ram_hit & ~s_q.pd;
   assign cmd_start = wr && (avs_address == OFF_CMD) && avs_writedata[CMD_START];
   assign ch_base = RAM_CH + 7'(s_q.ch) * 7'(CH_WORDS);
   assign st_base = RAM_ST + 7'({s_q.dec_eval, 1'b0});
   assign tim_w = ram[ch_base];
   assign int_w = ram[ch_base + 7'h1];
   assign eval_w = ram[ch_base + 7'h2];
   assign ta = ram[st_base];
   assign tb = ram[st_base + 7'h1];
   assign st_we = (s_q.fsm == S_EVAL) && eval_w[CHE_STORE] && ~s_q.pd;

   // Memory content is never reset; software must seed it before use.
   always_ff @(posedge sys_clk) begin
      if (ram_we) begin
         ram[ram_idx] <= avs_writedata;
      end
      if (st_we) begin
         ram[RAM_BUF + 7'(s_q.buf_wr)] <= 32'(lk.count);
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   assign lk.presc = s_q.presc;
   assign lk.top = s_q.top;
   assign lk.lf_tick = lf_tick;
   assign lk.clr = (s_q.fsm == S_LOAD);
   assign lk.cnt_en = (s_q.fsm == S_MEASURE);
   assign lk.pulse = comp_pulse;
   assign lk.thr = eval_w[CHE_THR_LSB +: THR_W];
   assign lk.less = eval_w[CHE_LESS];

   slsu_period_gen u_period (.sys_clk(sys_clk), .resetn(resetn), .lk(lk.period_end));
   slsu_pulse_count u_count (.sys_clk(sys_clk), .resetn(resetn), .lk(lk.count_end));

   logic [NCH-1:0] idle_out, idle_oe, idle_dac;
   for (genvar i = 0; i < NCH; i++) begin : g_idle
      logic [1:0] cfg;
      assign cfg = s_q.idle_conf[2*i +: 2];
      assign idle_out[i] = (cfg == IDLE_HIGH);
      assign idle_oe[i] = (cfg != IDLE_DIS) && (cfg != IDLE_DAC);
      assign idle_dac[i] = (cfg == IDLE_DAC);
   end

   logic match_a, match_b;
   assign match_a = (((s_q.sens_state ^ ta[TC_COMP_LSB +: 4]) & ~ta[TC_MASK_LSB +: 4]) == 4'h0);
   assign match_b = (((s_q.sens_state ^ tb[TC_COMP_LSB +: 4]) & ~tb[TC_MASK_LSB +: 4]) == 4'h0);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic fire;
      logic [1:0] act;
      s_d = s_q;
      fire = 1'b0;
      act = ACT_NONE;
      // Read data is captured on the first request cycle; the write lands on the completing edge.
      s_d.wait_r = ~(req & s_q.wait_r);
      if (req && s_q.wait_r) begin
         s_d.rdata = '0;
         if (ram_hit) begin
            s_d.rdata = s_q.pd ? '0 : ram[ram_idx];
         end else begin
            case (avs_address)
               OFF_CTRL: s_d.rdata = 32'(s_q.mode);
               OFF_TIMCTRL: s_d.rdata = (32'(s_q.top) << TIM_TOP_LSB) | (32'(s_q.presc) << TIM_PRESC_LSB);
               OFF_DECCTRL: s_d.rdata = 32'(s_q.cnt_out_en);
               OFF_CHANNEL_ENABLE_REG: s_d.rdata = 32'(s_q.channel_enable_reg);
               OFF_SCAN_RESULT_VECTOR: s_d.rdata = 32'(s_q.scan_res);
               OFF_STATUS: s_d.rdata = {30'h0, s_q.fsm != S_IDLE, s_q.running};
               OFF_PTR: s_d.rdata = 32'(s_q.buf_wr);
               OFF_DECODER_STATE_REG: s_d.rdata = 32'(s_q.dec_state);
               OFF_SENSSTATE: s_d.rdata = 32'(s_q.sens_state);
               OFF_IDLE_PIN_CONFIG: s_d.rdata = 32'(s_q.idle_conf);
               OFF_PWRDN: s_d.rdata = 32'(s_q.pd);
               default: s_d.rdata = '0;
            endcase
         end
      end
      if (wr) begin
         case (avs_address)
            OFF_CTRL: s_d.mode = avs_writedata[1:0];
            OFF_TIMCTRL: begin
               s_d.presc = avs_writedata[TIM_PRESC_LSB +: PRESC_W];
               s_d.top = avs_writedata[TIM_TOP_LSB +: TOP_W];
            end
            OFF_DECCTRL: s_d.cnt_out_en = avs_writedata[0];
            OFF_CMD: begin
               if (avs_writedata[CMD_STOP]) begin
                  s_d.running = 1'b0;
               end
               if (avs_writedata[CMD_START]) begin
                  s_d.running = 1'b1;
               end
            end
            OFF_CHANNEL_ENABLE_REG: s_d.channel_enable_reg = avs_writedata[NCH-1:0];
            OFF_DECODER_STATE_REG: s_d.dec_state = avs_writedata[3:0];
            OFF_SENSSTATE: s_d.sens_state = avs_writedata[3:0];
            OFF_IDLE_PIN_CONFIG: s_d.idle_conf = avs_writedata[2*NCH-1:0];
            OFF_PWRDN: s_d.pd = s_q.pd | avs_writedata[PWRDN_RAM];
            default: ;
         endcase
      end
      case (s_q.fsm)
         S_IDLE: begin
            if (s_q.running && ((s_q.mode == MODE_ONESHOT) || lk.tick)) begin
               s_d.fsm = S_LOAD;
               s_d.ch = '0;
               s_d.acc = '0;
            end
         end
         S_LOAD: begin
            s_d.ex_low = int_w[CHI_EXLOW];
            if (!s_q.channel_enable_reg[s_q.ch]) begin
               s_d.fsm = S_NEXT;
            end else if (tim_w[CHT_EXT_LSB +: EXT_W] == '0) begin
               s_d.tcnt = tim_w[CHT_SDLY_LSB +: SDLY_W];
               s_d.fsm = S_MEASURE;
            end else begin
               s_d.tcnt = SDLY_W'(tim_w[CHT_EXT_LSB +: EXT_W]);
               s_d.fsm = S_EXCITE;
            end
         end
         S_EXCITE: begin
            if (aux_tick) begin
               s_d.tcnt = s_q.tcnt - 1'b1;
               if (s_q.tcnt == SDLY_W'(1)) begin
                  s_d.tcnt = tim_w[CHT_SDLY_LSB +: SDLY_W];
                  s_d.fsm = S_MEASURE;
               end
            end
         end
         S_MEASURE: begin
            if (s_q.tcnt == '0) begin
               s_d.fsm = S_EVAL;
            end else if (lf_tick) begin
               s_d.tcnt = s_q.tcnt - 1'b1;
            end
         end
         S_EVAL: begin
            s_d.acc[s_q.ch] = lk.active;
            if (st_we) begin
               s_d.buf_wr = s_q.buf_wr + 1'b1;
            end
            s_d.fsm = S_NEXT;
         end
         S_NEXT: begin
            if (s_q.ch == CH_W'(NCH - 1)) begin
               s_d.scan_res = s_q.acc;
               s_d.sens_state = s_q.acc[3:0];
               s_d.dec_eval = s_q.dec_state;
               s_d.chained = 1'b0;
               s_d.fsm = S_DECODE;
            end else begin
               s_d.ch = s_q.ch + 1'b1;
               s_d.fsm = S_LOAD;
            end
         end
         S_DECODE: begin
            s_d.fsm = S_IDLE;
            if (s_q.mode == MODE_ONESHOT) begin
               s_d.running = 1'b0;
            end
            if (match_a) begin
               s_d.dec_state = ta[TC_NEXT_LSB +: 4];
               act = ta[TC_ACT_LSB +: 2];
            end else if (match_b) begin
               s_d.dec_state = tb[TC_NEXT_LSB +: 4];
               act = tb[TC_ACT_LSB +: 2];
            end else if (ta[TC_CHAIN] && !s_q.chained) begin
               s_d.dec_eval = s_q.dec_eval + 1'b1;
               s_d.chained = 1'b1;
               s_d.fsm = S_DECODE;
            end
            fire = (act != ACT_NONE);
         end
         default: s_d.fsm = S_IDLE;
      endcase
      s_d.ev[NCH-1:0] = s_d.scan_res;
      if (s_q.cnt_out_en) begin
         s_d.ev[NCH] = fire;
         if (fire) begin
            s_d.ev[NCH+1] = (act == ACT_UP);
         end
         s_d.ev[NCH+2] = 1'b0;
      end else begin
         s_d.ev[NCH +: NUM_DEC_EV] = s_d.dec_state[NUM_DEC_EV-1:0];
      end
      s_d.pin_out = idle_out;
      s_d.pin_oe = idle_oe;
      s_d.dac_sel = idle_dac;
      if (s_q.fsm == S_EXCITE) begin
         s_d.pin_oe[s_q.ch] = 1'b1;
         s_d.pin_out[s_q.ch] = ~s_q.ex_low;
         s_d.dac_sel[s_q.ch] = 1'b0;
      end else if (s_q.fsm == S_MEASURE) begin
         s_d.pin_oe[s_q.ch] = 1'b0;
         s_d.dac_sel[s_q.ch] = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.fsm <= S_IDLE;
         s_q.wait_r <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.wait_r;
   assign event_out = s_q.ev;
   assign pin_out = s_q.pin_out;
   assign pin_oe = s_q.pin_oe;
   assign dac_sel = s_q.dac_sel;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_scan_res_events: assert property (@(posedge sys_clk) disable iff (!resetn)
      event_out[NCH-1:0] == s_q.scan_res) else $error("Scan result events differ.");
   a_pd_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_q.pd |=> s_q.pd) else $error("Memory power-down cleared.");
   a_pd_set: assert property (@(posedge sys_clk) disable iff (!resetn)
      (wr && avs_address == OFF_PWRDN && avs_writedata[PWRDN_RAM]) |=> s_q.pd) else $error("Power-down not set.");
   a_start_runs: assert property (@(posedge sys_clk) disable iff (!resetn)
      (cmd_start && s_q.fsm == S_IDLE && s_q.mode == MODE_ONESHOT && !avs_writedata[CMD_STOP])
      |=> s_q.running ##1 (s_q.fsm == S_LOAD))
      else $error("Start did not begin a scan.");
   a_skip_excite: assert property (@(posedge sys_clk) disable iff (!resetn)
      (s_q.fsm == S_LOAD && s_q.channel_enable_reg[s_q.ch] && tim_w[CHT_EXT_LSB +: EXT_W] == '0) |=> (s_q.fsm == S_MEASURE))
      else $error("Excitation not skipped.");
   a_excite_low: assert property (@(posedge sys_clk) disable iff (!resetn)
      (s_q.fsm == S_EXCITE && s_q.ex_low) |=> (pin_oe[$past(s_q.ch)] && !pin_out[$past(s_q.ch)]))
      else $error("Low excitation not driven.");
   a_eval_less: assert property (@(posedge sys_clk) disable iff (!resetn)
      (s_q.fsm == S_EVAL && lk.less && lk.count < lk.thr) |=> s_q.acc[$past(s_q.ch)]) else $error("Sensor not active.");
   a_period_start: assert property (@(posedge sys_clk) disable iff (!resetn)
      (lk.tick && s_q.running && s_q.mode == MODE_PERIODIC && s_q.fsm == S_IDLE) |=> (s_q.fsm == S_LOAD))
      else $error("Period overflow did not start scan.");
   a_ram_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_q.pd |-> !ram_we && !st_we) else $error("Memory written after power-down.");
endmodule // slsu_top

// [tb/slsu_sensor_model.sv]
// Far-side model: low-frequency and fast oscillator ticks, comparator pulses.
// Assumes one system clock; pulses come only while every sensor pin is released.
`timescale 1ns/1ps
module slsu_sensor_model #(
   parameter int LF_DIV = 4,
   parameter int AUX_DIV = 3
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [15:0] pin_oe,
   output logic lf_tick,
   output logic aux_tick,
   output logic comp_pulse
);
   int lf_n;
   int aux_n;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         lf_n <= 0;
         aux_n <= 0;
         comp_pulse <= 1'b0;
      end else begin
         lf_n <= (lf_n == LF_DIV - 1) ? 0 : lf_n + 1;
         aux_n <= (aux_n == AUX_DIV - 1) ? 0 : aux_n + 1;
         comp_pulse <= !comp_pulse && (pin_oe == 16'h0000);
      end
   end
   assign lf_tick = (lf_n == LF_DIV - 1);
   assign aux_tick = (aux_n == AUX_DIV - 1);
endmodule // slsu_sensor_model

// [tb/sensor_scan_ram_event_outputs_bench.sv]
// Self-checking bench for the sensor scan unit over its Avalon-MM slave.
// Assumes the far-side model supplies ticks and comparator pulses.
`timescale 1ns/1ps
module sensor_scan_ram_event_outputs_bench;
   import slsu_pkg::*;
   localparam int LF = 4;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic lf_tick, aux_tick, comp_pulse;
   logic [18:0] event_out;
   logic [15:0] pin_out, pin_oe, dac_sel;
   logic [31:0] q;
   logic oe0_prev = 1'b0;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int oe0_n = 0;
   int oe1_n = 0;
   int bad_lvl = 0;
   int pulse_n = 0;
   int i;
   int rise_at[$];
   logic [31:0] tim [4] = '{32'h203, 32'h200, 32'h200, 32'h200};
   logic [31:0] eva [4] = '{32'h3FFFF, 32'h10000, 32'h0, 32'hFFFF};
   logic [9:0] da [6] = '{10'h228, 10'h22C, 10'h218, 10'h21C, 10'h230, 10'h234};
   logic [31:0] dd [6] = '{32'h1305, 32'hF, 32'h168D, 32'hF, 32'h2205, 32'hF};

   always #4 sys_clk = ~sys_clk;

   slsu_top u_slsu_top (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .lf_tick, .aux_tick, .comp_pulse, .event_out, .pin_out,
      .pin_oe, .dac_sel);
   slsu_sensor_model #(.LF_DIV(LF), .AUX_DIV(3)) u_slsu_sensor_model (.sys_clk, .resetn, .pin_oe,
      .lf_tick, .aux_tick, .comp_pulse);

   always @(posedge sys_clk) begin
      cyc++;
      oe0_prev <= pin_oe[0];
      if (pin_oe[0] === 1'b1) oe0_n++;
      if (pin_oe[0] === 1'b1 && pin_out[0] !== 1'b0) bad_lvl++;
      if (pin_oe[1] === 1'b1) oe1_n++;
      if (pin_oe[0] === 1'b1 && oe0_prev === 1'b0) rise_at.push_back(cyc);
      if (event_out[16] === 1'b1) pulse_n++;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      // Waitrequest is looked at mid-cycle, where the registered answer has settled.
      do begin
         @(negedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) n_errors++;
      q = avs_readdata;
      @(posedge sys_clk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rc(input logic [9:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask

   // Starts one scan and polls the running flag until it drops.
   task automatic scan();
      int n;
      n = 0;
      oe0_n = 0;
      oe1_n = 0;
      bus(1'b1, OFF_CMD, 32'h1);
      do begin
         bus(1'b0, OFF_STATUS, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 100);
      if (n >= 100) n_errors++;
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      print_verdict();
   end

   initial begin
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk("event_rst", 32'h0, 32'(event_out));
      chk("wait_rst", 32'h1, 32'(avs_waitrequest));
      bus(1'b1, 10'h100, 32'hFFFF);
      rc(10'h100, 32'h0, "unmapped");
      bus(1'b1, OFF_CHANNEL_ENABLE_REG, 32'hF);
      rc(OFF_CHANNEL_ENABLE_REG, 32'hF, "channel_enable_reg");
      rc(OFF_CMD, 32'h0, "cmd");
      bus(1'b1, OFF_CTRL, 32'h1);
      bus(1'b1, OFF_IDLE_PIN_CONFIG, 32'hC);
      for (i = 0; i < 4; i++) begin
         bus(1'b1, 10'(10'h2C0 + 12 * i), tim[i]);
         bus(1'b1, 10'(10'h2C4 + 12 * i), 32'(i == 0));
         bus(1'b1, 10'(10'h2C8 + 12 * i), eva[i]);
      end
      for (i = 0; i < 6; i++) bus(1'b1, da[i], dd[i]);
      bus(1'b1, OFF_DECODER_STATE_REG, 32'h5);
      scan();
      rc(OFF_SCAN_RESULT_VECTOR, 32'h5, "scan_result_vector");
      chk("event_res", 32'h5, 32'(event_out[15:0]));
      rc(OFF_SENSSTATE, 32'h5, "sensstate");
      rc(OFF_PTR, 32'h1, "ptr");
      chk("excite_len", 32'h1, 32'(oe0_n >= 6 && oe0_n <= 10));
      chk("excite_low", 32'h0, bad_lvl);
      chk("no_excite", 32'h0, oe1_n);
      chk("dac_idle", 32'h2, 32'(dac_sel[1:0]));
      chk("dec_state_ev", 32'h3, 32'(event_out[18:16]));
      scan();
      rc(OFF_DECODER_STATE_REG, 32'h6, "masked");
      bus(1'b1, OFF_DECCTRL, 32'h1);
      pulse_n = 0;
      scan();
      rc(OFF_DECODER_STATE_REG, 32'h2, "dec_down");
      chk("count_pulse", 32'h1, pulse_n);
      chk("dir_down", 32'h0, 32'(event_out[18:17]));
      bus(1'b1, OFF_CTRL, 32'h0);
      bus(1'b1, OFF_TIMCTRL, 32'h27300);
      rc(OFF_TIMCTRL, 32'h27300, "timctrl");
      rise_at.delete();
      bus(1'b1, OFF_CMD, 32'h1);
      for (i = 0; i < 5000 && rise_at.size() < 2; i++) @(posedge sys_clk);
      chk("period", 320 * LF, rise_at.size() < 2 ? 0 : rise_at[1] - rise_at[0]);
      bus(1'b1, OFF_CMD, 32'h2);
      bus(1'b1, OFF_PWRDN, 32'h1);
      bus(1'b1, OFF_PWRDN, 32'h0);
      rc(OFF_PWRDN, 32'h1, "pwrdn");
      bus(1'b1, 10'h2C8, 32'h1234);
      rc(10'h2C8, 32'h0, "ram_off");
      rc(OFF_CHANNEL_ENABLE_REG, 32'hF, "channel_enable_reg_kept");
      print_verdict();
   end
endmodule // sensor_scan_ram_event_outputs_bench
